// [core/logic_cell_control.sv]
// Operation
// R1 - each gate channel bit 16..19 inverts that channel before the cell
// R2 - enable bit 15 runs the cell; cleared, all cell outputs are zero; code zeroes only the raw value, so bit 5 still inverts it to status and pin
// R3 - rise_irq_enable bit 11 raises interrupt on cell output rising edge
// R4 - fall_irq_enable bit 10 raises interrupt on cell output falling edge
// R5 - software should not set both edge interrupt enables together
// R6 - cell drives its port pin only while bit 7 is one
// R7 - bit 6 shows cell output level, read-only, writes ignored
// R8 - unimplemented control bits read zero and ignore writes
// R9 - bit 5 inverts final cell output before status, edges and pin
// R10 - reset clears all control bits and status; cell off, interrupts off
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_defines.svh"

module logic_cell_control (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [3:0] chan_in,
    output logic cell_pin_out,
    output logic cell_pin_oe_n,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [3:0] gate_polarity;
        logic enable;
        logic rise_irq_enable;
        logic fall_irq_enable;
        logic cell_pin_output_enable;
        logic cell_output_invert;
        logic [2:0] mode;
        logic cell_raw;
        logic cell_output_state;
        logic [`LC_IRQ_WIDTH-1:0] irq_status;
        logic [`LC_IRQ_WIDTH-1:0] irq_enable;
        logic [31:0] rdata;
        logic pin_out;
    } cell_state_t;

    cell_state_t st_r;
    cell_state_t st_nxt;

    logic [3:0] gated;
    logic rise_ev;
    logic fall_ev;
    logic cell_fn;
    logic [31:0] ctrl_view;
    logic [`LC_IRQ_WIDTH-1:0] events;
    logic [`LC_IRQ_WIDTH-1:0] clr_bits;

    ////////////////////////////////////////////////////////////////////
    // gate channel polarity

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
            gate_channel u_chan (
                .chan_in(chan_in[gi]),
                .invert(st_r.gate_polarity[gi]), // [R1]
                .chan_out(gated[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // cell function; latch and flop modes use the held raw value
    always_comb begin
        unique case (logic_cell_pkg::cell_mode_t'(st_r.mode))
            logic_cell_pkg::fn_and_or: cell_fn = (gated[0] & gated[1]) | (gated[2] & gated[3]);
            logic_cell_pkg::fn_or_xor: cell_fn = (gated[0] | gated[1]) ^ (gated[2] | gated[3]);
            logic_cell_pkg::fn_and4: cell_fn = &gated;
            logic_cell_pkg::fn_sr_latch: begin
                cell_fn = (gated[0] | gated[1]) | (st_r.cell_raw & ~(gated[2] | gated[3]));
            end
            logic_cell_pkg::fn_d_ff: cell_fn = gated[1];
            logic_cell_pkg::fn_or4: cell_fn = |gated;
            logic_cell_pkg::fn_xor4: cell_fn = ^gated;
            logic_cell_pkg::fn_nand4: cell_fn = ~(&gated);
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // edges of the visible output level
    edge_detect u_edge (
        .mclk(mclk),
        .rst(rst),
        .level(st_r.cell_output_state),
        .rise(rise_ev),
        .fall(fall_ev)
    );

    // simultaneous enables both fire; software is told not to do that
    assign events[`LC_IRQ_RISE_BIT] = rise_ev & st_r.rise_irq_enable; // [R3] [R5]
    assign events[`LC_IRQ_FALL_BIT] = fall_ev & st_r.fall_irq_enable; // [R4]
    assign clr_bits = (wr && addr == `LC_IRQ_CLEAR_ADDR) ? wdata[`LC_IRQ_WIDTH-1:0] : '0;

    // readback view of the control word, unimplemented bits zero
    always_comb begin
        ctrl_view = 32'h0000_0000; // [R8]
        ctrl_view[`LC_GATE_POL_MSB:`LC_GATE_POL_LSB] = st_r.gate_polarity;
        ctrl_view[`LC_ENABLE_BIT] = st_r.enable;
        ctrl_view[`LC_RISE_IRQ_BIT] = st_r.rise_irq_enable;
        ctrl_view[`LC_FALL_IRQ_BIT] = st_r.fall_irq_enable;
        ctrl_view[`LC_PIN_OE_BIT] = st_r.cell_pin_output_enable;
        ctrl_view[`LC_OUT_STATE_BIT] = st_r.cell_output_state; // [R7]
        ctrl_view[`LC_OUT_INV_BIT] = st_r.cell_output_invert;
        ctrl_view[`LC_MODE_MSB:`LC_MODE_LSB] = st_r.mode;
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [31:0] w;
        w = wdata & `LC_CONTROL_WMASK; // [R8]
        st_nxt = st_r;
        if (wr && addr == `LC_CONTROL_ADDR) begin
            // status bit 6 is not in the write mask
            st_nxt.gate_polarity = w[`LC_GATE_POL_MSB:`LC_GATE_POL_LSB];
            st_nxt.enable = w[`LC_ENABLE_BIT];
            st_nxt.rise_irq_enable = w[`LC_RISE_IRQ_BIT];
            st_nxt.fall_irq_enable = w[`LC_FALL_IRQ_BIT];
            st_nxt.cell_pin_output_enable = w[`LC_PIN_OE_BIT];
            st_nxt.cell_output_invert = w[`LC_OUT_INV_BIT];
            st_nxt.mode = w[`LC_MODE_MSB:`LC_MODE_LSB];
        end
        if (wr && addr == `LC_IRQ_ENABLE_ADDR) begin
            st_nxt.irq_enable = wdata[`LC_IRQ_WIDTH-1:0];
        end
        // set wins over clear
        st_nxt.irq_status = (st_r.irq_status & ~clr_bits) | events;
        // disabled cell holds its raw value at zero; bit 5 invert still applies after it
        if (st_r.enable) begin
            st_nxt.cell_raw = (st_r.mode == 3'h4) ? (rise_chk(gated[0]) ? gated[1] : st_r.cell_raw)
                : cell_fn; // [R2]
        end else begin
            st_nxt.cell_raw = 1'b0; // [R2]
        end
        st_nxt.cell_output_state = st_nxt.cell_raw ^ st_r.cell_output_invert; // [R9] [R7]
        st_nxt.pin_out = st_nxt.cell_output_state & st_r.cell_pin_output_enable; // [R6]
        st_nxt.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                `LC_CONTROL_ADDR: st_nxt.rdata = ctrl_view;
                `LC_IRQ_STATUS_ADDR: st_nxt.rdata[`LC_IRQ_WIDTH-1:0] = st_r.irq_status;
                `LC_IRQ_ENABLE_ADDR: st_nxt.rdata[`LC_IRQ_WIDTH-1:0] = st_r.irq_enable;
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // flop mode clocks on gate 0 high; simple level sample as clock
    function automatic logic rise_chk(input logic c);
        rise_chk = c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0; // [R10]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign cell_pin_out = st_r.pin_out;
    assign cell_pin_oe_n = ~st_r.cell_pin_output_enable; // [R6]
    assign irq = |(st_r.irq_status & st_r.irq_enable);

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence rise_seq;
        !st_r.cell_output_state ##1 st_r.cell_output_state;
    endsequence

    sequence fall_seq;
        st_r.cell_output_state ##1 !st_r.cell_output_state;
    endsequence

    gate_invert_a: assert property (@(posedge mclk) disable iff (rst) // [R1]
        st_r.enable && st_r.mode == 3'h6 |=> st_r.cell_raw == $past(^(chan_in ^ st_r.gate_polarity)))
        else $error("gate polarity not applied");

    disabled_zero_a: assert property (@(posedge mclk) disable iff (rst) // [R2]
        !st_r.enable |=> !st_r.cell_raw && !cell_pin_out)
        else $error("disabled cell output not zero");

    rise_irq_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
        st_r.rise_irq_enable ##0 rise_seq |=> st_r.irq_status[`LC_IRQ_RISE_BIT])
        else $error("rising edge did not set status");

    fall_irq_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
        st_r.fall_irq_enable ##0 fall_seq |=> st_r.irq_status[`LC_IRQ_FALL_BIT])
        else $error("falling edge did not set status");

    no_rise_irq_a: assert property (@(posedge mclk) disable iff (rst) // [R3]
        !st_r.irq_status[`LC_IRQ_RISE_BIT] && !st_r.rise_irq_enable |=>
        !st_r.irq_status[`LC_IRQ_RISE_BIT])
        else $error("rise status set while disabled");

    pin_gate_a: assert property (@(posedge mclk) disable iff (rst) // [R6]
        cell_pin_out |-> $past(st_r.cell_pin_output_enable) && !cell_pin_oe_n == st_r.cell_pin_output_enable)
        else $error("pin driven while disabled");

    status_ro_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
        st_r.cell_output_state == (st_r.cell_raw ^ $past(st_r.cell_output_invert)))
        else $error("status bit does not follow cell");

    ctrl_zero_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
        $past(rd) && $past(addr) == `LC_CONTROL_ADDR |-> (rdata & 32'hfff0_7318) == 32'h0)
        else $error("unimplemented bits read nonzero");

    reset_clear_a: assert property (@(posedge mclk) // [R10]
        rst |=> st_r.enable == 1'b0 && irq == 1'b0 && st_r.cell_output_state == 1'b0)
        else $error("reset did not clear state");

endmodule

`default_nettype wire

// [include/logic_cell_defines.svh]
`ifndef LOGIC_CELL_DEFINES_SVH
`define LOGIC_CELL_DEFINES_SVH

// register byte addresses
`define LC_CONTROL_ADDR 8'h00
`define LC_IRQ_STATUS_ADDR 8'h04
`define LC_IRQ_CLEAR_ADDR 8'h08
`define LC_IRQ_ENABLE_ADDR 8'h0c

// control register field positions
`define LC_GATE_POL_LSB 16
`define LC_GATE_POL_MSB 19
`define LC_ENABLE_BIT 15
`define LC_RISE_IRQ_BIT 11
`define LC_FALL_IRQ_BIT 10
`define LC_PIN_OE_BIT 7
`define LC_OUT_STATE_BIT 6
`define LC_OUT_INV_BIT 5
`define LC_MODE_LSB 0
`define LC_MODE_MSB 2

// writable control bits: 19-16, 15, 11, 10, 7, 5, 2-0
`define LC_CONTROL_WMASK 32'h000f_8ca7
`define LC_CONTROL_RESET 32'h0000_0000

// interrupt status layout
`define LC_IRQ_RISE_BIT 0
`define LC_IRQ_FALL_BIT 1
`define LC_IRQ_WIDTH 2

`endif

// [include/logic_cell_pkg.sv]
package logic_cell_pkg;

    // cell combining functions selected by the mode field
    typedef enum logic [2:0] {
        fn_and_or = 3'h0,
        fn_or_xor = 3'h1,
        fn_and4 = 3'h2,
        fn_sr_latch = 3'h3,
        fn_d_ff = 3'h4,
        fn_or4 = 3'h5,
        fn_xor4 = 3'h6,
        fn_nand4 = 3'h7
    } cell_mode_t;

    typedef enum logic [1:0] {
        edge_none = 2'h0,
        edge_rise = 2'h1,
        edge_fall = 2'h2
    } edge_kind_t;

endpackage

// [core/gate_channel.sv]
`timescale 1ns/1ps
`default_nettype none

// one gate channel: optional inversion before the cell
module gate_channel (
    input wire logic chan_in,
    input wire logic invert,
    output logic chan_out
);

    // polarity applied combinationally, cell registers the result
    assign chan_out = chan_in ^ invert;

endmodule

`default_nettype wire

// [core/edge_detect.sv]
`timescale 1ns/1ps
`default_nettype none

// edge detector on the registered cell output
module edge_detect (
    input wire logic mclk,
    input wire logic rst,
    input wire logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t st_r;
    edge_state_t st_nxt;

    // remember last level
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = level;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = level & ~st_r.prev;
    assign fall = ~level & st_r.prev;

endmodule

`default_nettype wire

// [verif/chan_source.sv]
`timescale 1ns/1ps
`default_nettype none

// on-chip gate sources feeding the cell channels
module chan_source (
    input wire logic mclk,
    input wire logic [3:0] level_req,
    output logic [3:0] chan_in
);
    logic [3:0] held_r = 4'h0;

    // registered so a channel never moves near the sampling edge
    always_ff @(posedge mclk) begin
        held_r <= level_req;
    end

    assign chan_in = held_r;
endmodule

`default_nettype wire

// [verif/logic_cell_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_defines.svh"

module logic_cell_control_test;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [3:0] chan;
        logic st;
    } row_t;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [3:0] level_req = 4'h0;
    logic [3:0] chan_in;
    logic cell_pin_out;
    logic cell_pin_oe_n;
    logic irq;
    logic [31:0] got;
    int num_errors = 0;
    int n_tests = 0;
    row_t rows [9];

    // 10 MHz clock
    initial begin
        forever #50 mclk = ~mclk;
    end

    chan_source src (.mclk(mclk), .level_req(level_req), .chan_in(chan_in));

    logic_cell_control DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .chan_in(chan_in), .cell_pin_out(cell_pin_out),
        .cell_pin_oe_n(cell_pin_oe_n), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (exp !== seen) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle strobes, changed just after the edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        got = rdata;
    endtask

    task automatic set_chan(input logic [3:0] v);
        level_req <= v;
        repeat (5) @(posedge mclk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
    endtask

    task automatic chk_idle;
        chk("pin", 32'h0, {31'h0, cell_pin_out});
        chk("oe_n", 32'h1, {31'h0, cell_pin_oe_n});
        chk("irq", 32'h0, {31'h0, irq});
        bus_rd(`LC_CONTROL_ADDR);
        chk("control", `LC_CONTROL_RESET, got);
        bus_rd(`LC_IRQ_STATUS_ADDR);
        chk("status", 32'h0, got);
    endtask

    // hang guard, far beyond the 150 or so cycles the tests take
    initial begin
        #400000;
        num_errors++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{32'h0000_8005, 4'h0, 1'b0};
        rows[1] = '{32'h0000_8085, 4'h2, 1'b1};
        rows[2] = '{32'h000f_8085, 4'hf, 1'b0};
        rows[3] = '{32'h0001_8085, 4'h0, 1'b1};
        rows[4] = '{32'h0000_80a5, 4'h0, 1'b1};
        rows[5] = '{32'h0000_0085, 4'hf, 1'b0};
        rows[6] = '{32'hfff0_70df, 4'hf, 1'b0};
        rows[7] = '{32'h0000_8002, 4'hf, 1'b1};
        rows[8] = '{32'h0000_8006, 4'h7, 1'b1};
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_idle();
        $display("reset test done");
        // table: or4, and4, xor4 with polarity, invert, enable and pin enable
        for (int i = 0; i < 9; i++) begin
            bus_wr(`LC_CONTROL_ADDR, rows[i].ctrl);
            set_chan(rows[i].chan);
            bus_rd(`LC_CONTROL_ADDR);
            chk("control", (rows[i].ctrl & `LC_CONTROL_WMASK) | {25'h0, rows[i].st, 6'h0}, got);
            chk("pin", {31'h0, rows[i].st & rows[i].ctrl[7]}, {31'h0, cell_pin_out});
            chk("oe_n", {31'h0, ~rows[i].ctrl[7]}, {31'h0, cell_pin_oe_n});
            $display("row %0d done", i);
        end
        // edge interrupts, masking and clearing; one edge enable at a time
        bus_wr(`LC_IRQ_ENABLE_ADDR, 32'h3);
        bus_wr(`LC_CONTROL_ADDR, 32'h0000_8805);
        bus_wr(`LC_IRQ_CLEAR_ADDR, 32'h3);
        set_chan(4'h0);
        bus_rd(`LC_IRQ_STATUS_ADDR);
        chk("status", 32'h0, got);
        set_chan(4'h2);
        bus_rd(`LC_IRQ_STATUS_ADDR);
        chk("status", 32'h1, got);
        chk("irq", 32'h1, {31'h0, irq});
        bus_wr(`LC_IRQ_ENABLE_ADDR, 32'h0);
        set_chan(4'h2);
        chk("irq", 32'h0, {31'h0, irq});
        bus_wr(`LC_IRQ_ENABLE_ADDR, 32'h3);
        bus_wr(`LC_IRQ_CLEAR_ADDR, 32'h1);
        bus_rd(`LC_IRQ_STATUS_ADDR);
        chk("status", 32'h0, got);
        chk("irq", 32'h0, {31'h0, irq});
        bus_wr(`LC_CONTROL_ADDR, 32'h0000_8405);
        set_chan(4'h0);
        set_chan(4'h2);
        bus_rd(`LC_IRQ_STATUS_ADDR);
        chk("status", 32'h2, got);
        chk("irq", 32'h1, {31'h0, irq});
        $display("interrupt test done");
        // unmapped place reads zero and keeps nothing
        bus_wr(8'h10, 32'hffff_ffff);
        bus_rd(8'h10);
        chk("unmapped", 32'h0, got);
        bus_rd(`LC_CONTROL_ADDR);
        chk("control", 32'h0000_8445, got);
        $display("unmapped test done");
        // second reset in mid-run with the cell enabled and a fall interrupt pending
        do_reset();
        chk_idle();
        $display("mid-run reset test done");
        final_report();
    end
endmodule

`default_nettype wire
